// ---- inc/cmc_pkg.sv ----
package cmc_pkg;

   typedef logic [7:0] cmc_byte_t;

   localparam cmc_byte_t ADDR_STATUS = 8'hC0;
   localparam cmc_byte_t ADDR_TEMP = 8'hC1;
   localparam cmc_byte_t ADDR_FIELD_X = 8'hC2;
   localparam cmc_byte_t ADDR_FIELD_Y = 8'hC3;
   localparam cmc_byte_t ADDR_FIELD_Z = 8'hC4;
   localparam cmc_byte_t ADDR_OP_SELECT = 8'hE0;
   localparam cmc_byte_t ADDR_COND = 8'hE1;
   localparam cmc_byte_t ADDR_CUR_READ = 8'hFF;

   localparam logic [1:0] MODE_MEASURE = 2'h0;
   localparam logic [1:0] MODE_EEPROM = 2'h2;
   localparam logic [1:0] MODE_POWER_DOWN = 2'h3;
   localparam int OP_MODE_LSB = 0;

   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_EEP_BIT = 2;

   localparam cmc_byte_t COND_RESET = 8'h00;
   localparam cmc_byte_t RESULT_RESET = 8'h00;
   localparam cmc_byte_t PTR_RESET = 8'hC0;
   localparam logic [4:0] SLAVE_ADDR_HIGH = 5'h07;

   localparam int CLK_PERIOD_NS = 5;
   localparam int TOTAL_MEASURE_TIME_NS = 12560000;
   localparam int MEAS_CYCLES = TOTAL_MEASURE_TIME_NS / CLK_PERIOD_NS;
   localparam int SPIKE_FILTER_WIDTH_NS = 50;
   localparam int SPIKE_CYCLES = SPIKE_FILTER_WIDTH_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      ST_PD = 3'h0,
      ST_TEMP = 3'h1,
      ST_X = 3'h3,
      ST_Y = 3'h2,
      ST_Z = 3'h6,
      ST_EEP = 3'h4
   } cmc_state_e;

   // Sequential reads wrap inside the status and result block (Z back to status) and the write block.
   function automatic cmc_byte_t next_addr(input cmc_byte_t a);
      if (a == ADDR_FIELD_Z) begin
         return ADDR_STATUS;
      end else if (a == ADDR_COND) begin
         return ADDR_OP_SELECT;
      end
      return a + 8'h01;
   endfunction

   function automatic logic is_result(input cmc_byte_t a);
      return (a >= ADDR_TEMP) && (a <= ADDR_FIELD_Z);
   endfunction
endpackage

// ---- inc/cmc_pin_if.sv ----
`timescale 1ns/1ps
interface cmc_pin_if;
   logic scl;
   logic sda;
   logic [1:0] addr_sel;
   logic pin_rst;
   modport cond (output scl, output sda, output addr_sel, output pin_rst);
   modport core (input scl, input sda, input addr_sel, input pin_rst);
endinterface

// ---- verilog/cmc_pin_cond.sv ----
`timescale 1ns/1ps
module cmc_pin_cond #(
   parameter int SPIKE_CYC = cmc_pkg::SPIKE_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic scl_pin,
   input wire logic sda_pin,
   input wire logic [1:0] addr_sel_pins,
   input wire logic reset_low_pin,
   cmc_pin_if.cond pins
);
   import cmc_pkg::*;
   localparam int CW = $clog2(SPIKE_CYC + 1);

   logic [4:0] meta_r, meta_nxt, sync_r, sync_nxt;
   logic [1:0] filt_r, filt_nxt;
   logic [CW-1:0] cnt_r [2];
   logic [CW-1:0] cnt_nxt [2];

   ////////////////////////////////////////////////////////////////////////////////
   // An SCL or SDA level is taken only after it has differed from the filtered level
   // for SPIKE_CYC+1 samples, so narrower pulses never reach the core.
   always_comb begin
      meta_nxt = {reset_low_pin, addr_sel_pins, sda_pin, scl_pin};
      sync_nxt = meta_r;
      for (int i = 0; i < 2; i++) begin
         filt_nxt[i] = filt_r[i];
         cnt_nxt[i] = '0;
         if (sync_r[i] != filt_r[i]) begin
            if (cnt_r[i] == CW'(SPIKE_CYC)) begin
               filt_nxt[i] = sync_r[i];
            end else begin
               cnt_nxt[i] = cnt_r[i] + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= 5'h13;
         sync_r <= 5'h13;
         filt_r <= 2'h3;
         cnt_r[0] <= '0;
         cnt_r[1] <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         filt_r <= filt_nxt;
         cnt_r[0] <= cnt_nxt[0];
         cnt_r[1] <= cnt_nxt[1];
      end
   end

   assign pins.scl = filt_r[0];
   assign pins.sda = filt_r[1];
   assign pins.addr_sel = sync_r[3:2];
   assign pins.pin_rst = ~sync_r[4];

   ////////////////////////////////////////////////////////////////////////////////
   a_filt_hold: assert property (@(posedge clk) disable iff (rst)
      (sync_r[0] != filt_r[0] && cnt_r[0] != CW'(SPIKE_CYC)) |=> filt_r[0] == $past(filt_r[0]))
      else $error("Clock line followed a short spike.");
   a_filt_take: assert property (@(posedge clk) disable iff (rst)
      (sync_r[1] != filt_r[1] && cnt_r[1] == CW'(SPIKE_CYC)) |=> filt_r[1] == $past(sync_r[1]))
      else $error("Data line missed a stable level.");
endmodule // cmc_pin_cond

// ---- verilog/cmc_top.sv ----
`timescale 1ns/1ps
module cmc_top #(
   parameter int MEAS_CYCLES = cmc_pkg::MEAS_CYCLES,
   parameter int SPIKE_CYCLES = cmc_pkg::SPIKE_CYCLES
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic ASYNC_RESET_LOW_PIN,
   input wire logic SCL_PIN,
   input wire logic SDA_PIN,
   input wire logic [1:0] BUS_ADDR_SELECT_PINS,
   input wire cmc_pkg::cmc_byte_t REG_ADDR,
   input wire cmc_pkg::cmc_byte_t REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output cmc_pkg::cmc_byte_t REG_RDATA,
   input wire cmc_pkg::cmc_byte_t ADC_DATA,
   output logic [1:0] ADC_CHANNEL,
   output logic ANALOG_ON,
   output cmc_pkg::cmc_byte_t COND_OUT,
   output logic DONE_INT_PIN,
   output logic ADDR_MATCH
);
   import cmc_pkg::*;
   localparam int PHASE_CYC = MEAS_CYCLES / 4;
   localparam int CW = $clog2(PHASE_CYC + 1);

   cmc_pin_if pins ();
   logic core_rst;

   cmc_pin_cond #(.SPIKE_CYC(SPIKE_CYCLES)) u_pin_cond (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .scl_pin(SCL_PIN),
      .sda_pin(SDA_PIN),
      .addr_sel_pins(BUS_ADDR_SELECT_PINS),
      .reset_low_pin(ASYNC_RESET_LOW_PIN),
      .pins(pins)
   );

   // The reset pin is synchronised first, so it acts like a second sync reset.
   assign core_rst = SYS_RST | pins.pin_rst;

   ////////////////////////////////////////////////////////////////////////////////
   cmc_state_e state_r, state_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   cmc_byte_t temp_result_reg_r, temp_result_reg_nxt;
   cmc_byte_t field_x_result_reg_r, field_x_result_reg_nxt;
   cmc_byte_t field_y_result_reg_r, field_y_result_reg_nxt;
   cmc_byte_t field_z_result_reg_r, field_z_result_reg_nxt;
   logic done_r, done_nxt;
   logic analog_r, analog_nxt;
   logic [1:0] chan_r, chan_nxt;
   logic op_wr, phase_end, result_read;
   logic [1:0] mode;
   cmc_byte_t rd_addr;
   cmc_byte_t ptr_r, ptr_nxt;

   assign op_wr = REG_WR && (REG_ADDR == ADDR_OP_SELECT);
   assign mode = REG_WDATA[OP_MODE_LSB +: 2];
   assign phase_end = (cnt_r == CW'(PHASE_CYC - 1));
   assign rd_addr = (REG_ADDR == ADDR_CUR_READ) ? ptr_r : REG_ADDR;
   assign result_read = REG_RD && is_result(rd_addr);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = '0;
      temp_result_reg_nxt = temp_result_reg_r;
      field_x_result_reg_nxt = field_x_result_reg_r;
      field_y_result_reg_nxt = field_y_result_reg_r;
      field_z_result_reg_nxt = field_z_result_reg_r;
      done_nxt = done_r;
      if (result_read) begin
         done_nxt = 1'b0;
      end
      unique case (state_r)
         ST_PD: begin
            // Bus traffic other than a mode write never wakes the sequencer.
            if (op_wr && ((mode == MODE_MEASURE && !done_r) || mode == MODE_EEPROM)) begin
               state_nxt = (mode == MODE_MEASURE) ? ST_TEMP : ST_EEP;
               field_x_result_reg_nxt = RESULT_RESET;
               field_y_result_reg_nxt = RESULT_RESET;
               field_z_result_reg_nxt = RESULT_RESET;
            end
         end
         ST_TEMP: begin
            cnt_nxt = phase_end ? '0 : cnt_r + 1'b1;
            if (phase_end) begin
               temp_result_reg_nxt = ADC_DATA;
               state_nxt = ST_X;
            end
         end
         ST_X: begin
            cnt_nxt = phase_end ? '0 : cnt_r + 1'b1;
            if (phase_end) begin
               field_x_result_reg_nxt = ADC_DATA;
               state_nxt = ST_Y;
            end
         end
         ST_Y: begin
            cnt_nxt = phase_end ? '0 : cnt_r + 1'b1;
            if (phase_end) begin
               field_y_result_reg_nxt = ADC_DATA;
               state_nxt = ST_Z;
            end
         end
         ST_Z: begin
            cnt_nxt = phase_end ? '0 : cnt_r + 1'b1;
            if (phase_end) begin
               field_z_result_reg_nxt = ADC_DATA;
               state_nxt = ST_PD;
               done_nxt = 1'b1;
            end
         end
         ST_EEP: begin
            // Other mode codes are refused here: the way out is via power-down.
            if (op_wr && mode == MODE_POWER_DOWN) begin
               state_nxt = ST_PD;
            end
         end
         default: begin
            state_nxt = ST_PD;
         end
      endcase
      analog_nxt = (state_nxt inside {ST_TEMP, ST_X, ST_Y, ST_Z});
      chan_nxt = 2'h0;
      unique case (state_nxt)
         ST_X: chan_nxt = 2'h1;
         ST_Y: chan_nxt = 2'h2;
         ST_Z: chan_nxt = 2'h3;
         default: chan_nxt = 2'h0;
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (core_rst) begin
         state_r <= ST_PD;
         cnt_r <= '0;
         temp_result_reg_r <= RESULT_RESET;
         field_x_result_reg_r <= RESULT_RESET;
         field_y_result_reg_r <= RESULT_RESET;
         field_z_result_reg_r <= RESULT_RESET;
         done_r <= 1'b0;
         analog_r <= 1'b0;
         chan_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         temp_result_reg_r <= temp_result_reg_nxt;
         field_x_result_reg_r <= field_x_result_reg_nxt;
         field_y_result_reg_r <= field_y_result_reg_nxt;
         field_z_result_reg_r <= field_z_result_reg_nxt;
         done_r <= done_nxt;
         analog_r <= analog_nxt;
         chan_r <= chan_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   cmc_byte_t cond_r, cond_nxt;
   cmc_byte_t rd_data_r, rd_data_nxt;
   cmc_byte_t status;

   assign status = {5'h00, state_r == ST_EEP, analog_r, done_r};

   always_comb begin
      cond_nxt = cond_r;
      ptr_nxt = ptr_r;
      rd_data_nxt = 8'h00;
      // Conditions are only taken while the sequencer is in power-down (ST_PD), not in memory mode.
      if (REG_WR && REG_ADDR == ADDR_COND && state_r == ST_PD) begin
         cond_nxt = REG_WDATA;
      end
      if (REG_RD) begin
         ptr_nxt = next_addr(rd_addr);
         unique case (rd_addr)
            ADDR_STATUS: rd_data_nxt = status;
            ADDR_TEMP: rd_data_nxt = temp_result_reg_r;
            ADDR_FIELD_X: rd_data_nxt = field_x_result_reg_r;
            ADDR_FIELD_Y: rd_data_nxt = field_y_result_reg_r;
            ADDR_FIELD_Z: rd_data_nxt = field_z_result_reg_r;
            ADDR_COND: rd_data_nxt = cond_r;
            default: rd_data_nxt = 8'h00;
         endcase
      end else if (REG_WR && REG_ADDR != ADDR_CUR_READ) begin
         ptr_nxt = next_addr(REG_ADDR);
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (core_rst) begin
         cond_r <= COND_RESET;
         ptr_r <= PTR_RESET;
         rd_data_r <= 8'h00;
      end else begin
         cond_r <= cond_nxt;
         ptr_r <= ptr_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Slave address recogniser on the filtered bus lines.
   logic scl_d_r, scl_d_nxt, sda_d_r, sda_d_nxt;
   logic active_r, active_nxt, match_r, match_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic [6:0] shift_r, shift_nxt;

   always_comb begin
      scl_d_nxt = pins.scl;
      sda_d_nxt = pins.sda;
      active_nxt = active_r;
      match_nxt = match_r;
      bit_nxt = bit_r;
      shift_nxt = shift_r;
      if (pins.scl && scl_d_r && sda_d_r && !pins.sda) begin
         active_nxt = 1'b1;
         match_nxt = 1'b0;
         bit_nxt = 3'h0;
      end else if (pins.scl && scl_d_r && !sda_d_r && pins.sda) begin
         active_nxt = 1'b0;
         match_nxt = 1'b0;
      end else if (active_r && pins.scl && !scl_d_r) begin
         shift_nxt = {shift_r[5:0], pins.sda};
         bit_nxt = bit_r + 3'h1;
         if (bit_r == 3'h7) begin
            active_nxt = 1'b0;
            match_nxt = (shift_r == {SLAVE_ADDR_HIGH, pins.addr_sel});
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (core_rst) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         active_r <= 1'b0;
         match_r <= 1'b0;
         bit_r <= 3'h0;
         shift_r <= 7'h00;
      end else begin
         scl_d_r <= scl_d_nxt;
         sda_d_r <= sda_d_nxt;
         active_r <= active_nxt;
         match_r <= match_nxt;
         bit_r <= bit_nxt;
         shift_r <= shift_nxt;
      end
   end

   assign REG_RDATA = rd_data_r;
   assign ADC_CHANNEL = chan_r;
   assign ANALOG_ON = analog_r;
   assign COND_OUT = cond_r;
   assign DONE_INT_PIN = done_r;
   assign ADDR_MATCH = match_r;

   ////////////////////////////////////////////////////////////////////////////////
   logic [31:0] len_r;
   always_ff @(posedge REF_CLK) begin
      len_r <= (state_r == ST_PD || state_r == ST_EEP) ? 32'h0 : len_r + 32'h1;
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (core_rst);

   a_meas_blocked: assert property (
      (state_r == ST_PD && op_wr && mode == MODE_MEASURE && done_r) |=> state_r == ST_PD)
      else $error("Measurement started while done was set.");
   a_eep_exit_pd: assert property (
      (state_r == ST_EEP) |=> (state_r == ST_EEP || state_r == ST_PD))
      else $error("Memory mode left for a mode other than power-down.");
   a_done_raise: assert property (
      (state_r == ST_Z && phase_end) |=> (done_r && DONE_INT_PIN && state_r == ST_PD))
      else $error("Done not raised on return to power-down.");
   a_done_drop: assert property (
      (result_read && !(state_r == ST_Z && phase_end)) |=> !DONE_INT_PIN)
      else $error("Result read did not drop done.");
   a_axes_clear: assert property (
      (state_r == ST_PD && state_nxt != ST_PD) |=>
         (field_x_result_reg_r == 8'h00 && field_y_result_reg_r == 8'h00
          && field_z_result_reg_r == 8'h00))
      else $error("Axis results not cleared on leaving power-down.");
   a_meas_length: assert property (
      (state_r == ST_Z && phase_end) |-> len_r == 32'(4 * PHASE_CYC - 1))
      else $error("Measurement length is wrong.");
   a_cond_kept: assert property (
      (state_r != ST_PD) |=> cond_r == $past(cond_r))
      else $error("Condition changed outside power-down.");
   a_pd_hold: assert property (
      (state_r == ST_PD && !op_wr) |=> (state_r == ST_PD && !ANALOG_ON))
      else $error("Sequencer left power-down without a mode write.");
   a_addr_match: assert property (
      $rose(ADDR_MATCH) |-> $past(shift_r) == {SLAVE_ADDR_HIGH, $past(pins.addr_sel)})
      else $error("Address matched a foreign slave address.");

   c_meas_done: cover property ((state_r == ST_Z && phase_end) ##1 DONE_INT_PIN);
   c_eep_entry: cover property (state_r == ST_PD ##1 state_r == ST_EEP);
   c_blocked: cover property (state_r == ST_PD && op_wr && mode == MODE_MEASURE && done_r);
   c_cur_read: cover property (REG_RD && REG_ADDR == ADDR_CUR_READ && result_read);
   c_addr_hit: cover property ($rose(ADDR_MATCH));
endmodule // cmc_top

// ---- verification/cmc_host_model.sv ----
`timescale 1ns/1ps
module cmc_host_model (
   output logic scl,
   output logic sda
);
   // Both lines are driven high from time zero, so idle lines read high.
   // SCL stands still between frames.
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end

   ////////////////////////////////////////////////////////////
   // Start plus one address byte, MSB first, with data changed only while SCL is low.
   // SCL is then left high so that the caller can look at the match flag.
   // The glitch is a deliberate 4 ns spike on SCL inside a low period.
   task automatic send_start(input logic [7:0] b, input logic glitch);
      #1.3;
      sda = 1'b0;
      #40;
      for (int i = 7; i >= 0; i--) begin
         scl = 1'b0;
         #10;
         if (glitch && i == 4) begin
            scl = 1'b1;
            #4;
            scl = 1'b0;
            #6;
         end else begin
            #10;
         end
         sda = b[i];
         #20;
         scl = 1'b1;
         #40;
      end
      #60;
   endtask

   // The device never acknowledges, so the host drives SDA high itself for the ninth bit.
   task automatic send_stop();
      scl = 1'b0;
      #20;
      sda = 1'b1;
      #20;
      scl = 1'b1;
      #40;
      scl = 1'b0;
      #20;
      sda = 1'b0;
      #20;
      scl = 1'b1;
      #20;
      sda = 1'b1;
      #40;
   endtask
endmodule // cmc_host_model

// ---- verification/tb_compass_measure_mode_control.sv ----
`timescale 1ns/1ps
module tb_compass_measure_mode_control;
   import cmc_pkg::*;
   localparam int MEAS_CYC = 40;
   localparam real PD_WAIT = 100000.0;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic pin_rst_n = 1'b1;
   logic [1:0] sel = 2'h0;
   cmc_byte_t addr = 8'h00;
   cmc_byte_t wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_d = 1'b0;
   cmc_byte_t adc = 8'h00;
   cmc_byte_t rdata;
   cmc_byte_t cond;
   logic [1:0] chan;
   logic aon;
   logic done;
   logic match;
   logic done_d = 1'b0;
   logic on_d = 1'b0;
   logic [1:0] last_ch = 2'h3;
   wire scl;
   wire sda;
   int fail_count = 0;
   int check_count = 0;
   int on_cnt = 0;
   cmc_byte_t exp_q[$];
   logic [1:0] ch_seq[$];
   cmc_byte_t vals[4] = '{default: 8'h00};
   cmc_byte_t v;
   cmc_byte_t cv;
   logic [31:0] seed = 32'h25;
   realtime pd_time = 0.0;

   always #2.5 clk = ~clk;

   cmc_top #(
      .MEAS_CYCLES(MEAS_CYC),
      .SPIKE_CYCLES(2)
   ) cmc_top_inst (
      .REF_CLK(clk),
      .SYS_RST(rst),
      .ASYNC_RESET_LOW_PIN(pin_rst_n),
      .SCL_PIN(scl),
      .SDA_PIN(sda),
      .BUS_ADDR_SELECT_PINS(sel),
      .REG_ADDR(addr),
      .REG_WDATA(wdata),
      .REG_WR(wr),
      .REG_RD(rd),
      .REG_RDATA(rdata),
      .ADC_DATA(adc),
      .ADC_CHANNEL(chan),
      .ANALOG_ON(aon),
      .COND_OUT(cond),
      .DONE_INT_PIN(done),
      .ADDR_MATCH(match)
   );

   cmc_host_model cmc_host_model_inst (
      .scl(scl),
      .sda(sda)
   );

   ////////////////////////////////////////////////////////////
   task automatic chk(input cmc_byte_t got, input cmc_byte_t exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks=%0d mismatches=%0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   function automatic cmc_byte_t rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   task automatic wr_reg(input cmc_byte_t a, input cmc_byte_t d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input cmc_byte_t a, input cmc_byte_t e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      exp_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask

   // A mode other than power-down is only written once the settling time has passed.
   task automatic pd_wait();
      while ($realtime - pd_time < PD_WAIT) @(posedge clk);
   endtask

   task automatic wait_done();
      for (int i = 0; i < 4 * MEAS_CYC; i++) begin
         @(posedge clk);
         if (done === 1'b1) return;
      end
      fail_count++;
      give_verdict();
   endtask

   task automatic measure();
      if (done !== 1'b0) rd_reg(ADDR_TEMP, vals[0]);
      for (int i = 0; i < 4; i++) vals[i] = rnd();
      pd_wait();
      wr_reg(ADDR_OP_SELECT, {6'h00, MODE_MEASURE});
      rd_reg(ADDR_STATUS, 8'h02);
      wr_reg(ADDR_OP_SELECT, {6'h00, MODE_EEPROM});
      wait_done();
   endtask

   ////////////////////////////////////////////////////////////
   // The converter model answers with the value chosen for the selected channel.
   always @(posedge clk) adc <= vals[chan];

   always @(posedge clk) begin
      if (rd_d === 1'b1) begin
         chk(rdata, exp_q.pop_front());
      end
      rd_d <= rd;
   end

   always @(posedge clk) begin
      if (aon === 1'b1) begin
         on_cnt <= on_cnt + 1;
         if (chan !== last_ch) ch_seq.push_back(chan);
         last_ch <= chan;
      end
      if (done === 1'b1 && done_d === 1'b0) begin
         chk(8'(on_cnt), 8'(MEAS_CYC));
         chk({6'h00, on_d, aon}, 8'h02);
         chk(8'(ch_seq.size()), 8'h04);
         foreach (ch_seq[i]) chk({6'h00, ch_seq[i]}, 8'(i));
         ch_seq.delete();
         on_cnt <= 0;
         last_ch <= 2'h3;
         pd_time = $realtime;
      end
      done_d <= done;
      on_d <= aon;
   end

   ////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      pd_time = $realtime;
      @(posedge clk);
      #1;
      chk({6'h00, done, aon}, 8'h00);
      rd_reg(ADDR_STATUS, 8'h00);
      rd_reg(8'hA5, 8'h00);
      cv = rnd();
      wr_reg(ADDR_COND, cv);
      #1;
      chk(cond, cv);
      rd_reg(ADDR_COND, cv);
      $display("test reset and conditions finished");
      measure();
      rd_reg(ADDR_STATUS, 8'h01);
      pd_wait();
      wr_reg(ADDR_OP_SELECT, {6'h00, MODE_MEASURE});
      repeat (3) @(posedge clk);
      #1;
      chk({6'h00, aon, done}, 8'h01);
      rd_reg(ADDR_FIELD_Y, vals[2]);
      #1;
      chk({7'h00, done}, 8'h00);
      rd_reg(ADDR_CUR_READ, vals[3]);
      rd_reg(ADDR_CUR_READ, 8'h00);
      rd_reg(ADDR_CUR_READ, vals[0]);
      rd_reg(ADDR_CUR_READ, vals[1]);
      $display("test first measurement finished");
      measure();
      rd_reg(ADDR_STATUS, 8'h01);
      rd_reg(ADDR_CUR_READ, vals[0]);
      #1;
      chk({7'h00, done}, 8'h00);
      $display("test current address read finished");
      pd_wait();
      wr_reg(ADDR_OP_SELECT, 8'h01);
      rd_reg(ADDR_STATUS, 8'h00);
      wr_reg(ADDR_OP_SELECT, {6'h00, MODE_EEPROM});
      rd_reg(ADDR_STATUS, 8'h04);
      for (int i = 1; i < 4; i++) rd_reg(ADDR_TEMP + 8'(i), 8'h00);
      rd_reg(ADDR_TEMP, vals[0]);
      wr_reg(ADDR_COND, ~cv);
      rd_reg(ADDR_COND, cv);
      wr_reg(ADDR_OP_SELECT, {6'h00, MODE_MEASURE});
      rd_reg(ADDR_STATUS, 8'h04);
      wr_reg(ADDR_OP_SELECT, {6'h00, MODE_POWER_DOWN});
      pd_time = $realtime;
      rd_reg(ADDR_STATUS, 8'h00);
      rd_reg(ADDR_COND, cv);
      $display("test memory mode finished");
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         v = rnd();
         sel <= v[1:0];
         repeat (4) @(posedge clk);
         cmc_host_model_inst.send_start({5'h07, v[1:0], 1'b1}, i == 0);
         chk({7'h00, match}, 8'h01);
         chk({7'h00, aon}, 8'h00);
         cmc_host_model_inst.send_stop();
         chk({7'h00, match}, 8'h00);
         cmc_host_model_inst.send_start({5'h07, ~v[1:0], 1'b0}, 1'b0);
         chk({7'h00, match}, 8'h00);
         cmc_host_model_inst.send_stop();
      end
      $display("test bus addressing finished");
      @(posedge clk);
      pin_rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      pin_rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      rd_reg(ADDR_COND, COND_RESET);
      #1;
      chk(cond, COND_RESET);
      rd_reg(ADDR_STATUS, 8'h00);
      repeat (2) @(posedge clk);
      $display("test pin reset finished");
      give_verdict();
   end
endmodule // tb_compass_measure_mode_control
